// *** pkg/didt_defines.svh ***
// Encoding, field, register and response constants for the instruction decoder.
`ifndef DIDT_DEFINES_SVH
`define DIDT_DEFINES_SVH
`define DIDT_OP_NOP 8'h00
`define DIDT_OP_CALLI 8'h01
`define DIDT_OP_CALL 8'h02
`define DIDT_OP_GOTO 8'h04
`define DIDT_OP_RET 8'h05
`define DIDT_OP_IRET 8'h06
`define DIDT_OP_DO 8'h08
`define DIDT_OP_MOVD 8'h9E
`define DIDT_HI_COND 4'h3
`define DIDT_CC_ALW 4'h7
`define DIDT_HI_BIT 4'hA
`define DIDT_HI_TBL 4'hB
`define DIDT_HI_MAC 4'hC
`define DIDT_HI_FILE 4'hD
`define DIDT_HI_CSKIP 4'hE
`define DIDT_HI_DSP 4'hF
`define DIDT_W13 4'hD
`define DIDT_FM_ARITH 9'h01F
`define DIDT_FM_LOGIC 9'h014
`define DIDT_FM_DSP 9'h1E0
`define DIDT_A_CTRL 8'h00
`define DIDT_A_STAT 8'h04
`define DIDT_A_FLAG 8'h08
`define DIDT_A_ICNT 8'h0C
`define DIDT_RESP_OK 2'h0
`define DIDT_RESP_ERR 2'h2
`endif

// *** pkg/didt_pkg.sv ***
// Types shared by the instruction decoder and its users.
package didt_pkg;
  typedef enum logic [3:0] {
    C_NOP = 4'h0, C_DWORD = 4'h1, C_BRC = 4'h2, C_JMP = 4'h3,
    C_RET = 4'h4, C_TBL = 4'h5, C_SKIP = 4'h6, C_MOVD = 4'h7,
    C_WOP = 4'h8, C_FILE = 4'h9, C_BIT = 4'hA, C_MAC = 4'hB,
    C_DSP = 4'hC, C_OTHER = 4'hD
  } didt_cls_t;
  typedef enum logic [1:0] {ST_RUN = 2'b01, ST_STALL = 2'b10} didt_st_t;
  typedef struct packed {
    logic second_acc_clamped;
    logic first_acc_clamped;
    logic second_acc_overflow;
    logic first_acc_overflow;
    logic sticky_zero;
    logic signed_wrap_flag;
    logic negative;
    logic digit_carry_flag;
    logic carry;
  } didt_flags_t;
  typedef struct packed {
    logic [7:0] opcode;
    didt_cls_t cls;
    logic [1:0] cycles;
    logic two_word;
    logic [3:0] base_operand_reg;
    logic [3:0] source_operand_reg;
    logic [2:0] src_mode;
    logic [3:0] dest_operand_reg;
    logic [2:0] dst_mode;
    logic [12:0] file_addr;
    logic to_file;
    logic [3:0] bit_position_field;
    logic bit_from_reg;
    logic acc_sel;
    logic [2:0] mul_pair;
    logic [3:0] x_pf;
    logic [1:0] x_dst;
    logic [3:0] y_pf;
    logic [1:0] y_dst;
    logic [1:0] writeback_mode;
    logic [3:0] acc_writeback_reg;
    logic shift_from_reg;
    logic [3:0] shift_reg;
    logic [5:0] shift_lit;
    logic [15:0] literal;
    logic [8:0] flag_mask;
  } didt_dec_t;
  typedef struct packed {
    didt_st_t st;
    logic [1:0] left;
    logic rdy;
    logic issue;
    logic nop;
    logic [1:0] used;
    didt_dec_t dec;
    didt_flags_t flags;
    logic en;
    logic [15:0] icnt;
    logic awr;
    logic wr;
    logic [7:0] wa;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic bv;
    logic [1:0] br;
    logic arr;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } didt_state_t;
endpackage

// *** logic/didt_decoder.sv ***
// Instruction word decoder, cycle-count sequencer and status flags.
`timescale 1ns/1ps
`include "didt_defines.svh"

module didt_decoder
  import didt_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Fetch path.
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_word,
  input wire logic [23:0] fetch_next,
  input wire logic skip_cond,
  output logic fetch_ready,
  // Execution datapath.
  output logic issue_valid,
  output didt_dec_t issue_dec,
  output logic nop_slot,
  output logic [1:0] words_used,
  input wire logic flag_upd_valid,
  input wire didt_flags_t flag_upd_val,
  output didt_flags_t status_flags,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  didt_state_t s_q;
  didt_state_t s_d;

  function automatic logic is_dw(input logic [7:0] op);
    return op == `DIDT_OP_CALL || op == `DIDT_OP_GOTO ||
      op == `DIDT_OP_DO;
  endfunction

  function automatic didt_cls_t cls_of(input logic [7:0] op);
    didt_cls_t c;
    c = C_OTHER;
    if (op == `DIDT_OP_NOP) begin
      c = C_NOP;
    end else if (is_dw(op)) begin
      c = C_DWORD;
    end else if (op == `DIDT_OP_CALLI) begin
      c = C_JMP;
    end else if (op == `DIDT_OP_RET || op == `DIDT_OP_IRET) begin
      c = C_RET;
    end else if (op == `DIDT_OP_MOVD) begin
      c = C_MOVD;
    end else begin
      case (op[7:4])
        `DIDT_HI_COND: begin
          c = (op[3:0] == `DIDT_CC_ALW) ? C_JMP : C_BRC;
        end
        4'h4, 4'h5, 4'h6, 4'h7: begin
          c = C_WOP;
        end
        `DIDT_HI_BIT: begin
          c = op[3] ? C_SKIP : C_BIT;
        end
        `DIDT_HI_TBL: c = C_TBL;
        `DIDT_HI_MAC: c = C_MAC;
        `DIDT_HI_FILE: c = C_FILE;
        `DIDT_HI_CSKIP: c = C_SKIP;
        `DIDT_HI_DSP: c = C_DSP;
        default: c = C_OTHER;
      endcase
    end
    return c;
  endfunction

  // Branch condition against the flags as they stand when the word is accepted, a cycle before issue.
  function automatic logic cond_ok(input logic [3:0] cc, input didt_flags_t f);
    logic lt;
    lt = f.negative ^ f.signed_wrap_flag;
    case (cc)
      4'h0: return f.carry;
      4'h1: return !f.carry;
      4'h2: return f.negative;
      4'h3: return !f.negative;
      4'h4: return f.signed_wrap_flag;
      4'h5: return !f.signed_wrap_flag;
      4'h6: return f.sticky_zero;
      4'h8: return !lt;
      4'h9: return lt;
      4'hA: return !f.sticky_zero && !lt;
      4'hB: return f.sticky_zero || lt;
      4'hC: return f.carry && !f.sticky_zero;
      4'hD: return !f.carry || f.sticky_zero;
      default: return 1'b0;
    endcase
  endfunction

  function automatic didt_dec_t decode(
    input logic [23:0] w,
    input logic [23:0] nx,
    input logic tk,
    input logic nx2
  );
    didt_dec_t d;
    d = '0;
    d.opcode = w[23:16];
    d.cls = cls_of(w[23:16]);
    d.two_word = is_dw(w[23:16]);
    d.literal = d.two_word ? nx[15:0] : w[15:0];
    d.base_operand_reg = w[18:15];
    d.source_operand_reg = w[3:0];
    d.src_mode = w[6:4];
    d.dest_operand_reg = w[10:7];
    d.dst_mode = w[13:11];
    d.file_addr = w[12:0];
    d.to_file = w[13];
    d.bit_position_field = w[15:12];
    d.acc_sel = w[16];
    case (d.cls)
      C_WOP: begin
        d.flag_mask = w[21] ? `DIDT_FM_LOGIC : `DIDT_FM_ARITH;
      end
      C_FILE: d.flag_mask = `DIDT_FM_ARITH;
      C_BIT, C_SKIP: begin
        // Indirect bit number comes from a base register's contents.
        d.bit_from_reg = w[16];
        if (w[16]) begin
          d.base_operand_reg = w[11:8];
        end
      end
      C_MAC: begin
        d.mul_pair = w[15:13];
        d.x_pf = w[12:9];
        d.x_dst = w[8:7];
        d.y_pf = w[6:3];
        d.y_dst = w[2:1];
        // The reserved code leaves the accumulator unwritten.
        d.writeback_mode = (w[18:17] == 2'h3) ? 2'h0 : w[18:17];
        d.acc_writeback_reg = `DIDT_W13;
        d.flag_mask = `DIDT_FM_DSP;
      end
      C_DSP: begin
        d.shift_from_reg = w[15];
        d.shift_reg = w[10:7];
        d.shift_lit = w[12:7];
        d.flag_mask = `DIDT_FM_DSP;
      end
      default: d.flag_mask = 9'h000;
    endcase
    case (d.cls)
      C_DWORD, C_MOVD: d.cycles = 2'h2;
      C_JMP, C_TBL: d.cycles = 2'h2;
      C_RET: d.cycles = 2'h3;
      C_BRC: d.cycles = tk ? 2'h2 : 2'h1;
      C_SKIP: begin
        d.cycles = !tk ? 2'h1 : (nx2 ? 2'h3 : 2'h2);
      end
      default: d.cycles = 2'h1;
    endcase
    return d;
  endfunction

  logic acc;
  logic tk;
  didt_flags_t fl;
  didt_flags_t mk;

  always_comb begin
    s_d = s_q;
    s_d.issue = 1'b0;
    s_d.nop = 1'b0;
    acc = fetch_valid && s_q.rdy;
    tk = (cls_of(fetch_word[23:16]) == C_BRC) ?
      cond_ok(fetch_word[19:16], s_q.flags) : skip_cond;

    case (s_q.st)
      ST_RUN: begin
        s_d.rdy = s_q.en;
        if (acc) begin
          s_d.dec = decode(fetch_word, fetch_next, tk,
            is_dw(fetch_next[23:16]));
          s_d.issue = 1'b1;
          s_d.used = s_d.dec.two_word ? 2'h2 : 2'h1;
          s_d.icnt = s_q.icnt + 16'h1;
          // Extra cycles are dead slots; the fetch stalls through them.
          if (s_d.dec.cycles != 2'h1) begin
            s_d.st = ST_STALL;
            s_d.left = s_d.dec.cycles - 2'h1;
            s_d.rdy = 1'b0;
          end
        end
      end
      ST_STALL: begin
        s_d.nop = 1'b1;
        s_d.left = s_q.left - 2'h1;
        if (s_q.left == 2'h1) begin
          s_d.st = ST_RUN;
          s_d.rdy = s_q.en;
        end
      end
      default: begin
        s_d.st = ST_RUN;
        s_d.rdy = 1'b0;
      end
    endcase

    // AXI write: address and data are taken in either order.
    if (s_q.awr && s_axi_awvalid) begin
      s_d.awr = 1'b0;
      s_d.wa = s_axi_awaddr;
    end
    if (s_q.wr && s_axi_wvalid) begin
      s_d.wr = 1'b0;
      s_d.wdat = s_axi_wdata;
      s_d.wstb = s_axi_wstrb;
    end
    if (!s_q.awr && !s_q.wr && !s_q.bv) begin
      s_d.bv = 1'b1;
      s_d.br = `DIDT_RESP_OK;
      case (s_q.wa)
        `DIDT_A_CTRL: begin
          if (s_q.wstb[0]) begin
            s_d.en = s_q.wdat[0];
          end
        end
        `DIDT_A_FLAG: begin
          if (s_q.wstb[0]) begin
            s_d.flags[7:0] = s_q.wdat[7:0];
          end
          if (s_q.wstb[1]) begin
            s_d.flags[8] = s_q.wdat[8];
          end
        end
        `DIDT_A_STAT, `DIDT_A_ICNT: s_d.br = `DIDT_RESP_OK;
        default: s_d.br = `DIDT_RESP_ERR;
      endcase
    end
    if (s_q.bv && s_axi_bready) begin
      s_d.bv = 1'b0;
      s_d.awr = 1'b1;
      s_d.wr = 1'b1;
    end

    // Datapath flag results land after software so they are never lost.
    fl = s_d.flags;
    mk = s_q.dec.flag_mask;
    if (flag_upd_valid) begin
      s_d.flags = (fl & ~mk) | (flag_upd_val & mk);
      // Zero is sticky: a zero result cannot set it, only keep it.
      if (mk.sticky_zero) begin
        s_d.flags.sticky_zero = fl.sticky_zero &&
          flag_upd_val.sticky_zero;
      end
    end

    // AXI read.
    if (s_q.arr && s_axi_arvalid) begin
      s_d.arr = 1'b0;
      s_d.rv = 1'b1;
      s_d.rr = `DIDT_RESP_OK;
      case (s_axi_araddr)
        `DIDT_A_CTRL: s_d.rd = {31'h0, s_q.en};
        `DIDT_A_STAT: begin
          s_d.rd = {16'h0, s_q.dec.opcode, 4'h0, s_q.dec.two_word,
            s_q.dec.cycles, s_q.st == ST_STALL};
        end
        `DIDT_A_FLAG: s_d.rd = {23'h0, s_q.flags};
        `DIDT_A_ICNT: s_d.rd = {16'h0, s_q.icnt};
        default: begin
          s_d.rd = 32'h0;
          s_d.rr = `DIDT_RESP_ERR;
        end
      endcase
    end
    if (s_q.rv && s_axi_rready) begin
      s_d.rv = 1'b0;
      s_d.arr = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.st <= ST_RUN;
      s_q.awr <= 1'b1;
      s_q.wr <= 1'b1;
      s_q.arr <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign fetch_ready = s_q.rdy;
  assign issue_valid = s_q.issue;
  assign issue_dec = s_q.dec;
  assign nop_slot = s_q.nop;
  assign words_used = s_q.used;
  assign status_flags = s_q.flags;
  assign s_axi_awready = s_q.awr;
  assign s_axi_wready = s_q.wr;
  assign s_axi_bvalid = s_q.bv;
  assign s_axi_bresp = s_q.br;
  assign s_axi_arready = s_q.arr;
  assign s_axi_rvalid = s_q.rv;
  assign s_axi_rdata = s_q.rd;
  assign s_axi_rresp = s_q.rr;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_dword_cycles: assert property (
    issue_valid && issue_dec.two_word |->
      issue_dec.cycles == 2'h2 && words_used == 2'h2
  ) else $error("double-word instruction not two cycles");

  chk_lone_second: assert property (
    fetch_valid && fetch_ready && fetch_word[23:16] == `DIDT_OP_NOP |=>
      issue_valid && issue_dec.cls == C_NOP && issue_dec.cycles == 2'h1
  ) else $error("zero top byte not run as no-operation");

  chk_two_stall: assert property (
    issue_valid && issue_dec.cycles == 2'h2 |->
      !fetch_ready ##1 nop_slot ##1 !nop_slot
  ) else $error("two-cycle instruction stall wrong");

  chk_three_stall: assert property (
    issue_valid && issue_dec.cycles == 2'h3 |=>
      nop_slot [*2] ##1 !nop_slot
  ) else $error("three-cycle instruction stall wrong");

  chk_skip_long: assert property (
    fetch_valid && fetch_ready && skip_cond &&
      cls_of(fetch_word[23:16]) == C_SKIP && is_dw(fetch_next[23:16]) |=>
      issue_valid && issue_dec.cycles == 2'h3
  ) else $error("skip over double word not three cycles");

  chk_movd_len: assert property (
    fetch_valid && fetch_ready && fetch_word[23:16] == `DIDT_OP_MOVD |=>
      issue_valid && issue_dec.cycles == 2'h2
  ) else $error("double move not two cycles");

  chk_awb_target: assert property (
    fetch_valid && fetch_ready && cls_of(fetch_word[23:16]) == C_MAC |=>
      issue_dec.acc_writeback_reg == `DIDT_W13 &&
      issue_dec.writeback_mode != 2'h3
  ) else $error("write-back target is not register 13");

  chk_accept_issue: assert property (
    fetch_valid && fetch_ready |=>
      issue_valid && issue_dec.opcode == $past(fetch_word[23:16])
  ) else $error("accepted word not issued with its opcode");

  chk_file_dest: assert property (
    fetch_valid && fetch_ready &&
      cls_of(fetch_word[23:16]) == C_FILE |=>
      issue_dec.to_file == $past(fetch_word[13]) &&
      issue_dec.file_addr == $past(fetch_word[12:0])
  ) else $error("file register destination decoded wrong");

  chk_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)
  ) else $error("write response dropped before taken");

endmodule

// *** testbench/didt_fetch_model.sv ***
// Program memory fetch model that offers words to the instruction decoder.
`timescale 1ns/1ps
module didt_fetch_model (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Fetch handshake.
  input wire logic fetch_ready,
  output logic fetch_valid = 1'b0,
  output logic [23:0] fetch_word,
  output logic [23:0] fetch_next,
  output logic skip_cond
);
  logic [24:0] mem [0:63];
  int len = 0;
  int pc = 0;
  int npc = 0;
  int stall = 0;
  logic [7:0] op;
  assign op = mem[pc][23:16];
  // A word not on offer shows its inverse, so a stale value never passes for a live one.
  assign fetch_word = fetch_valid ? mem[pc][23:0] : ~mem[pc][23:0];
  assign fetch_next = fetch_valid ? mem[pc + 1][23:0] : ~mem[pc + 1][23:0];
  assign skip_cond = fetch_valid ? mem[pc][24] : ~mem[pc][24];
  always @(posedge aclk) begin
    if (!aresetn) begin
      fetch_valid <= 1'b0;
      pc <= 0;
    end else if (!fetch_valid || fetch_ready) begin
      npc = pc;
      // A double-word op takes both words, so the stream moves past the pair.
      if (fetch_valid) begin
        npc = pc + ((op == 8'h02 || op == 8'h04 || op == 8'h08) ? 2 : 1);
      end
      pc <= npc;
      fetch_valid <= (npc < len) && (($urandom % 100) >= stall);
    end
  end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the instruction decoder fed by the fetch model.
`timescale 1ns/1ps
module testbench
  import didt_pkg::*;
;
  logic aclk, aresetn, fetch_valid, fetch_ready, skip_cond, issue_valid, nop_slot;
  logic flag_upd_valid, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [23:0] fetch_word, fetch_next;
  logic [1:0] words_used, bresp, rresp;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  didt_dec_t issue_dec;
  didt_flags_t flag_upd_val, status_flags;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int acc_n = 0;
  int nops = 0;
  int pcyc = 0;
  logic [49:0] iq [$];
  logic [33:0] aq [$];
  logic [49:0] e;
  logic [33:0] a;
  logic [7:0] prog [0:27] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h04, 8'h00, 8'h08, 8'h00,
    8'h06, 8'h9E, 8'h37, 8'h30, 8'h31, 8'h3F, 8'hB5, 8'hE2, 8'h45, 8'hE3, 8'h02, 8'h00,
    8'hE4, 8'hAC, 8'hA3, 8'hC2, 8'hD1, 8'hF3, 8'h64, 8'h4A};
  logic [31:0] skm = 32'h0022_8000;

  didt_decoder dut (.aclk(aclk), .aresetn(aresetn), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_next(fetch_next), .skip_cond(skip_cond),
    .fetch_ready(fetch_ready), .issue_valid(issue_valid), .issue_dec(issue_dec),
    .nop_slot(nop_slot), .words_used(words_used), .flag_upd_valid(flag_upd_valid),
    .flag_upd_val(flag_upd_val), .status_flags(status_flags), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  didt_fetch_model fm (.aclk(aclk), .aresetn(aresetn), .fetch_ready(fetch_ready),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word), .fetch_next(fetch_next),
    .skip_cond(skip_cond));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic axw(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
    aq.push_back({r, 32'h0});
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] ad, input logic [33:0] x);
    aq.push_back(x);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask

  function automatic logic [1:0] exp_cyc(input logic [23:0] w, input logic [23:0] n,
                                         input logic s);
    logic [7:0] o;
    o = w[23:16];
    if (o[7:4] == 4'hE || (o[7:4] == 4'hA && o[3])) begin
      return s ? ((n[23:16] inside {8'h02, 8'h04, 8'h08}) ? 2'h3 : 2'h2) : 2'h1;
    end
    if (o == 8'h06) return 2'h3;
    if (o inside {8'h01, 8'h37, 8'h31} || o[7:4] == 4'hB) return 2'h2;
    if (o inside {8'h02, 8'h04, 8'h08, 8'h9E}) return 2'h2;
    return 2'h1;
  endfunction

  task automatic check_dec(input logic [49:0] x);
    logic [23:0] w;
    logic two;
    w = x[23:0];
    two = w[23:16] inside {8'h02, 8'h04, 8'h08};
    chk(issue_dec.opcode, w[23:16]);
    chk(issue_dec.cycles, x[49:48]);
    chk({issue_dec.two_word, words_used}, {two, two ? 2'h2 : 2'h1});
    if (two) chk(issue_dec.literal, x[39:24]);
    if (w[23:16] == 8'h00) chk(issue_dec.cls, C_NOP);
    case (w[23:20])
      4'h4, 4'h5, 4'h6, 4'h7: chk({issue_dec.base_operand_reg, issue_dec.source_operand_reg,
        issue_dec.dest_operand_reg}, {w[18:15], w[3:0], w[10:7]});
      4'hA: chk({issue_dec.bit_position_field, issue_dec.bit_from_reg}, {w[15:12], w[16]});
      4'hC: begin
        chk({issue_dec.acc_sel, issue_dec.mul_pair, issue_dec.x_pf, issue_dec.y_pf},
          {w[16], w[15:13], w[12:9], w[6:3]});
        if (w[18:17] inside {2'h1, 2'h2}) chk(issue_dec.acc_writeback_reg, 4'hD);
      end
      4'hD: chk({issue_dec.file_addr, issue_dec.to_file}, {w[12:0], w[13]});
      4'hF: chk({issue_dec.acc_sel, issue_dec.shift_from_reg}, {w[16], w[15]});
      default: ;
    endcase
  endtask

  // Notes each accepted word, then matches the oldest note when the decoder answers.
  always @(posedge aclk) begin
    cyc++;
    if (aresetn && fetch_valid && fetch_ready) begin
      acc_n++;
      iq.push_back({exp_cyc(fetch_word, fetch_next, skip_cond), fetch_next, fetch_word});
    end
    if (nop_slot) nops++;
    if (issue_valid) begin
      if (pcyc != 0) chk(nops, pcyc - 1);
      nops = 0;
      e = iq.pop_front();
      pcyc = e[49:48];
      check_dec(e);
    end
    if (bvalid && bready) begin
      a = aq.pop_front();
      chk(bresp, a[33:32]);
    end
    if (rvalid && rready) begin
      a = aq.pop_front();
      chk({rresp, rdata}, a);
    end
    // The ceiling sits far above the hundred or so cycles the tests need.
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    aresetn = 1'b0;
    flag_upd_valid = 1'b0;
    flag_upd_val = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    void'($urandom(32'hE335));
    for (int i = 0; i < 28; i++) fm.mem[i] = {skm[i], prog[i], 16'($urandom)};
    fm.mem[28] = '0;
    fm.stall = 25;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1 chk(fetch_ready, 1'b0);
    axr(8'h08, 34'h0);
    axr(8'h10, {2'h2, 32'h0});
    axw(8'h14, 32'h1, 2'h2);
    axr(8'h00, 34'h0);
    $display("test registers after reset done");
    fm.len = 28;
    axw(8'h00, 32'h1, 2'h0);
    for (int k = 0; k < 2000 && fm.pc < 28; k++) @(posedge aclk);
    chk(fm.pc, 34'h1C);
    axr(8'h0C, {18'h0, 16'(acc_n)});
    chk(nops, pcyc - 1);
    axr(8'h04, {2'h0, 32'h0000_4A02});
    $display("test instruction stream done");
    axw(8'h08, 32'h1FF, 2'h0);
    axr(8'h08, {2'h0, 32'h1FF});
    @(posedge aclk);
    flag_upd_valid <= 1'b1;
    @(posedge aclk);
    flag_upd_valid <= 1'b0;
    axr(8'h08, {2'h0, 32'h1E0});
    chk(status_flags, 9'h1E0);
    $display("test status flags done");
    close_out();
  end
endmodule
